// ---- rtl/ssm_pkg.sv ----
// Types of the supply supervisor mode logic.
package ssm_pkg;

  typedef enum logic [1:0] {
    SSM_OFF = 2'b00,
    SSM_NORMAL = 2'b01,
    SSM_FULL = 2'b11
  } ssm_state_t;

  typedef enum logic [1:0] {
    SSM_ACTIVE = 2'b00,
    SSM_LIGHT = 2'b01,
    SSM_DEEP = 2'b11
  } ssm_power_t;

  // One side's control bits.
  typedef struct packed {
    logic auto_control;
    logic sup_enable;
    logic sup_sleep_keep;
    logic sup_full_perf;
    logic mon_enable;
    logic mon_full_perf;
  } ssm_side_ctl_t;

  typedef struct packed {
    ssm_state_t low_supervisor;
    ssm_state_t low_monitor;
    ssm_state_t high_supervisor;
    ssm_state_t high_monitor;
  } ssm_states_t;

endpackage

// ---- rtl/ssm_regs.svh ----
// Constants of the supply supervisor mode logic: clock rate, reset value, counter width and timing counts.
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

`define SSM_CLK_FREQ_HZ 20000000
`define SSM_SETTLE_NORMAL_NS 150000
`define SSM_SETTLE_FULL_NS 2000
`define SSM_WAKE_SLOW_NS 150000
`define SSM_HAZARD_WINDOW_NS 1000
`define SSM_NS_PER_S 1000000000
// Least times round up to whole cycles.
`define SSM_CYC_UP(ns) ((((ns) * 64'd20) + 64'd999) / 64'd1000)
// Longest times round down.
`define SSM_CYC_DN(ns) (((ns) * 64'd20) / 64'd1000)
`define SSM_SETTLE_NORMAL_CYC `SSM_CYC_UP(`SSM_SETTLE_NORMAL_NS)
`define SSM_SETTLE_FULL_CYC `SSM_CYC_UP(`SSM_SETTLE_FULL_NS)
`define SSM_WAKE_SLOW_CYC `SSM_CYC_UP(`SSM_WAKE_SLOW_NS)
`define SSM_HAZARD_CYC `SSM_CYC_DN(`SSM_HAZARD_WINDOW_NS)
`define SSM_CNT_W 13
`define SSM_CTL_RESET 6'h00

`endif

// ---- rtl/ssm_supervisor.sv ----
// Supply supervisor and monitor mode selection, settling flags and wake-up path choice.
`timescale 1ns/1ns
`include "ssm_regs.svh"
// How it works
// - Fast wake-up path only when both the low supervisor and the low monitor are off or full performance.
// - Low supervisor without full performance gives slow wake-up, about 150 us.
// - High supervisor enabled, not full, sleep keep clear or keep plus auto, either low unit off or full: affected.
// - High monitor enabled, not full, auto control set, either low unit off or full: affected.
// - Under auto control a normal high supervisor or monitor turns off in deep sleep.
// - Affected configuration plus wake within about 1 us of deep entry hangs until reset.
// - Settling delay is about 150 us in normal mode and about 2 us in full mode.
module ssm_supervisor (
  input wire logic clk,
  input wire logic reset_n,
  input wire ssm_pkg::ssm_side_ctl_t low_ctl_in,
  input wire logic low_ctl_write,
  input wire ssm_pkg::ssm_side_ctl_t high_ctl_in,
  input wire logic high_ctl_write,
  input wire ssm_pkg::ssm_power_t power_mode,
  input wire logic wake_request,
  input wire logic soft_reset,
  output ssm_pkg::ssm_side_ctl_t low_side_control_reg,
  output ssm_pkg::ssm_side_ctl_t high_side_control_reg,
  output ssm_pkg::ssm_states_t state_reg,
  output logic low_side_settle_flag,
  output logic high_side_settle_flag,
  output logic fast_wake_reg,
  output logic affected_config_check,
  output logic wake_ack_reg,
  output logic hung_reg
);

  localparam logic [`SSM_CNT_W-1:0] NORMAL_CYC = `SSM_CNT_W'(`SSM_SETTLE_NORMAL_CYC);
  localparam logic [`SSM_CNT_W-1:0] FULL_CYC = `SSM_CNT_W'(`SSM_SETTLE_FULL_CYC);
  localparam logic [`SSM_CNT_W-1:0] SLOW_CYC = `SSM_CNT_W'(`SSM_WAKE_SLOW_CYC);
  localparam logic [`SSM_CNT_W-1:0] HAZ_CYC = `SSM_CNT_W'(`SSM_HAZARD_CYC);

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire logic deep = (power_mode == ssm_pkg::SSM_DEEP);

  function automatic ssm_pkg::ssm_state_t sup_state(input logic en, input logic keep,
                                                     input logic full, input logic auto_c,
                                                     input logic in_deep);
    ssm_pkg::ssm_state_t s;
    s = ssm_pkg::SSM_OFF;
    if (en) begin
      if (!in_deep) begin
        s = full ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
      end else if (keep) begin
        if (!auto_c) begin
          s = full ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
        end else begin
          s = full ? ssm_pkg::SSM_NORMAL : ssm_pkg::SSM_OFF;
        end
      end
    end
    return s;
  endfunction

  // Unit order follows the state word: low supervisor, low monitor, high supervisor, high monitor.
  // Monitors have no sleep keep bit; they always stay on under manual control.
  // The unused power code counts as awake, so a glitch on it can never switch a unit off.
  wire ssm_pkg::ssm_side_ctl_t lc = low_side_control_reg;
  wire ssm_pkg::ssm_side_ctl_t hc = high_side_control_reg;
  wire logic [3:0] unit_enable = {lc.sup_enable, lc.mon_enable, hc.sup_enable, hc.mon_enable};
  wire logic [3:0] unit_keep = {lc.sup_sleep_keep, 1'b1, hc.sup_sleep_keep, 1'b1};
  wire logic [3:0] unit_full = {lc.sup_full_perf, lc.mon_full_perf, hc.sup_full_perf, hc.mon_full_perf};
  wire logic [3:0] unit_auto = {lc.auto_control, lc.auto_control, hc.auto_control, hc.auto_control};
  wire logic [7:0] state_bits;

  genvar u;
  for (u = 0; u < 4; u = u + 1) begin : g_unit
    assign state_bits[2*u +: 2] = sup_state(unit_enable[u], unit_keep[u], unit_full[u], unit_auto[u], deep);
  end

  wire ssm_pkg::ssm_states_t state_next = ssm_pkg::ssm_states_t'(state_bits);

  // ****************************************************************
  // Wake-up path and affected configuration
  // ****************************************************************
  // The affected check calls the low side fast when either low unit is off or at full performance.
  wire logic low_fast = !lc.sup_enable || lc.sup_full_perf || !lc.mon_enable || lc.mon_full_perf;
  // The real wake path, though, is slow as soon as either enabled low unit runs in normal mode.
  // A normal low monitor alone is enough to slow it, even with the low supervisor off.
  wire logic low_sup_normal = lc.sup_enable && !lc.sup_full_perf;
  wire logic low_mon_normal = lc.mon_enable && !lc.mon_full_perf;
  wire logic fast_wake_next = !low_sup_normal && !low_mon_normal;
  wire logic high_sup_hit = hc.sup_enable && !hc.sup_full_perf &&
                            (!hc.sup_sleep_keep || hc.auto_control);
  wire logic high_mon_hit = hc.mon_enable && !hc.mon_full_perf && hc.auto_control;
  wire logic affected_next = low_fast && (high_sup_hit || high_mon_hit);

  // ****************************************************************
  // Settling delays
  // ****************************************************************
  // Reload uses the new setting: full-performance low side settles fast.
  wire logic [`SSM_CNT_W-1:0] low_load = low_ctl_in.sup_full_perf ? FULL_CYC : NORMAL_CYC;
  wire logic [`SSM_CNT_W-1:0] high_load = high_ctl_in.sup_full_perf ? FULL_CYC : NORMAL_CYC;
  logic [`SSM_CNT_W-1:0] low_cnt_reg;
  logic [`SSM_CNT_W-1:0] high_cnt_reg;
  logic [`SSM_CNT_W-1:0] wake_cnt_reg;
  logic [`SSM_CNT_W-1:0] entry_cnt_reg;
  logic deep_d_reg;
  wire logic deep_entry = deep && !deep_d_reg;
  wire logic wake_cnt_load = wake_request && deep && !hung_reg && wake_cnt_reg == '0 && !wake_ack_reg;
  wire logic [`SSM_CNT_W-1:0] wake_len_v = fast_wake_reg ? `SSM_CNT_W'(1) : SLOW_CYC;

  // The hazard needs an affected setting, or deep entry before the flags cleared.
  // It is modelled as a fixed window after entry; real silicon shows it only sometimes,
  // so this is the pessimistic case that software has to be written against.
  wire logic unsafe = affected_config_check || low_side_settle_flag || high_side_settle_flag;
  wire logic hang_now = wake_request && deep && entry_cnt_reg != '0 && unsafe;
  wire logic hung_next = soft_reset ? 1'b0 : (hung_reg || hang_now);

  // Counters stop at zero, so a finished delay never wraps round into a false flag.
  wire logic low_cnt_run = (low_cnt_reg != '0);
  wire logic high_cnt_run = (high_cnt_reg != '0);
  wire logic entry_cnt_run = (entry_cnt_reg != '0) && deep;
  wire logic wake_cnt_run = (wake_cnt_reg != '0);
  wire logic [`SSM_CNT_W-1:0] low_cnt_next = low_ctl_write ? low_load :
                                             (low_cnt_run ? low_cnt_reg - 1'b1 : '0);
  wire logic [`SSM_CNT_W-1:0] high_cnt_next = high_ctl_write ? high_load :
                                              (high_cnt_run ? high_cnt_reg - 1'b1 : '0);

  // Each flag drops on the edge at which its count reaches zero, so it stands for the whole load.
  wire logic low_flag_next = low_ctl_write || (low_cnt_reg > `SSM_CNT_W'(1));
  wire logic high_flag_next = high_ctl_write || (high_cnt_reg > `SSM_CNT_W'(1));

  // Leaving deep sleep inside the window closes it, so a quick exit and re-entry opens a fresh one.
  wire logic [`SSM_CNT_W-1:0] entry_cnt_next = deep_entry ? HAZ_CYC :
                                               (entry_cnt_run ? entry_cnt_reg - 1'b1 : '0);

  // A hang clears the wake counter, so no acknowledge can follow it until a reset.
  wire logic [`SSM_CNT_W-1:0] wake_cnt_next = (hang_now || hung_reg) ? '0 :
                                              (wake_cnt_load ? wake_len_v :
                                              (wake_cnt_run ? wake_cnt_reg - 1'b1 : '0));
  wire logic wake_ack_next = (wake_cnt_reg == `SSM_CNT_W'(1)) && !hung_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_side_control_reg <= ssm_pkg::ssm_side_ctl_t'(`SSM_CTL_RESET);
      high_side_control_reg <= ssm_pkg::ssm_side_ctl_t'(`SSM_CTL_RESET);
    end else if (soft_reset) begin
      low_side_control_reg <= ssm_pkg::ssm_side_ctl_t'(`SSM_CTL_RESET);
      high_side_control_reg <= ssm_pkg::ssm_side_ctl_t'(`SSM_CTL_RESET);
    end else begin
      if (low_ctl_write) begin
        low_side_control_reg <= low_ctl_in;
      end
      if (high_ctl_write) begin
        high_side_control_reg <= high_ctl_in;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_reg <= '0;
      high_cnt_reg <= '0;
      low_side_settle_flag <= 1'b0;
      high_side_settle_flag <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
      low_side_settle_flag <= low_flag_next;
      high_side_settle_flag <= high_flag_next;
    end
  end

  // ****************************************************************
  // Deep sleep entry, wake-up and hang
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deep_d_reg <= 1'b0;
      entry_cnt_reg <= '0;
      wake_cnt_reg <= '0;
      wake_ack_reg <= 1'b0;
      hung_reg <= 1'b0;
      state_reg <= '0;
      fast_wake_reg <= 1'b1;
      affected_config_check <= 1'b0;
    end else begin
      deep_d_reg <= deep;
      entry_cnt_reg <= entry_cnt_next;
      state_reg <= state_next;
      fast_wake_reg <= fast_wake_next;
      affected_config_check <= affected_next;
      // Only an external or soft reset leaves the hang.
      hung_reg <= hung_next;
      wake_cnt_reg <= wake_cnt_next;
      wake_ack_reg <= wake_ack_next;
    end
  end

endmodule

// ---- testbench/ssm_supervisor_assertions.sv ----
// Concurrent checks of the supply supervisor mode logic, bound to its top module.
`timescale 1ns/1ns
module ssm_supervisor_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire ssm_pkg::ssm_side_ctl_t low_ctl_in,
  input wire logic low_ctl_write,
  input wire logic high_ctl_write,
  input wire ssm_pkg::ssm_power_t power_mode,
  input wire logic wake_request,
  input wire ssm_pkg::ssm_side_ctl_t low_side_control_reg,
  input wire ssm_pkg::ssm_side_ctl_t high_side_control_reg,
  input wire ssm_pkg::ssm_states_t state_reg,
  input wire logic low_side_settle_flag,
  input wire logic high_side_settle_flag,
  input wire logic fast_wake_reg,
  input wire logic affected_config_check,
  input wire logic wake_ack_reg,
  input wire logic hung_reg
);
  // ****************************************
  // Reference mapping and settle counter
  // ****************************************
  logic [12:0] cnt_reg;
  function automatic logic [1:0] st(logic en, logic keep, logic full, logic auto_c, logic deep);
    if (!en || (deep && !keep)) return 2'h0;
    if (deep && auto_c) return {1'h0, full};
    return {full, 1'h1};
  endfunction
  // Monitors have no sleep-keep bit, so they behave as if it were always set.
  function automatic logic [3:0] side(ssm_pkg::ssm_side_ctl_t c, logic d);
    return {st(c.sup_enable, c.sup_sleep_keep, c.sup_full_perf, c.auto_control, d),
      st(c.mon_enable, 1'h1, c.mon_full_perf, c.auto_control, d)};
  endfunction
  function automatic logic fast(ssm_pkg::ssm_side_ctl_t c);
    return !(c.sup_enable && !c.sup_full_perf) && !(c.mon_enable && !c.mon_full_perf);
  endfunction
  function automatic logic hit(ssm_pkg::ssm_side_ctl_t l, ssm_pkg::ssm_side_ctl_t h);
    return (!l.sup_enable || l.sup_full_perf || !l.mon_enable || l.mon_full_perf)
      && ((h.sup_enable && !h.sup_full_perf && (!h.sup_sleep_keep || h.auto_control))
      || (h.mon_enable && !h.mon_full_perf && h.auto_control));
  endfunction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_reg <= 13'h0000;
    else if (low_ctl_write) cnt_reg <= 13'h0000;
    else if (low_side_settle_flag) cnt_reg <= cnt_reg + 13'h0001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_ctl_load: assert property (low_ctl_write |=> (low_side_control_reg == $past(low_ctl_in)) ##0 low_side_settle_flag[*8])
    else $error("low control write did not load or raise its settle flag");
  a_high_settle: assert property (high_ctl_write |=> high_side_settle_flag[*8])
    else $error("high settle flag did not stay up after a write");
  a_settle_len: assert property ($fell(low_side_settle_flag) |-> (low_side_control_reg.sup_full_perf ? cnt_reg inside {[13'h0026:13'h002A]} : cnt_reg inside {[13'h0BB6:13'h0BBA]}))
    else $error("low settle delay has the wrong length");
  a_fast_wake: assert property (fast_wake_reg == fast($past(low_side_control_reg)))
    else $error("wake path choice does not follow low side control");
  a_affected_map: assert property (affected_config_check == hit($past(low_side_control_reg), $past(high_side_control_reg)))
    else $error("affected configuration flag is wrong");
  a_state_map: assert property (state_reg == {side($past(low_side_control_reg), $past(power_mode) == ssm_pkg::SSM_DEEP), side($past(high_side_control_reg), $past(power_mode) == ssm_pkg::SSM_DEEP)})
    else $error("supervisor states do not match control and power mode");
  a_fast_ack: assert property ($rose(wake_request) && power_mode == ssm_pkg::SSM_DEEP && fast_wake_reg && !hung_reg && !affected_config_check && !low_side_settle_flag && !high_side_settle_flag |-> ##2 wake_ack_reg)
    else $error("fast wake did not complete in two cycles");
  a_hang_entry: assert property ($rose(power_mode == ssm_pkg::SSM_DEEP) ##1 (wake_request && affected_config_check) |=> hung_reg)
    else $error("early wake in affected configuration did not hang");
  c_settle_done: cover property ($fell(low_side_settle_flag));
  c_wake_done: cover property (wake_ack_reg);
  c_hang_seen: cover property ($rose(hung_reg));
endmodule
bind ssm_supervisor ssm_supervisor_assertions chk (.clk, .reset_n, .low_ctl_in, .low_ctl_write, .high_ctl_write,
  .power_mode, .wake_request, .low_side_control_reg, .high_side_control_reg, .state_reg, .low_side_settle_flag,
  .high_side_settle_flag, .fast_wake_reg, .affected_config_check, .wake_ack_reg, .hung_reg);

// ---- testbench/ssm_supervisor_tb.sv ----
// Self-checking bench of the supply supervisor mode logic.
`timescale 1ns/1ns
module ssm_supervisor_tb;
  typedef struct packed {
    logic [5:0] lo;
    logic [5:0] hi;
    logic [1:0] pm;
    logic [7:0] st;
    logic [7:0] fa;
  } ssm_row_t;
  logic clk, reset_n, low_ctl_write, high_ctl_write, wake_request, soft_reset;
  ssm_pkg::ssm_side_ctl_t low_ctl_in, high_ctl_in, low_side_control_reg, high_side_control_reg;
  ssm_pkg::ssm_power_t power_mode;
  ssm_pkg::ssm_states_t state_reg;
  logic low_side_settle_flag, high_side_settle_flag, fast_wake_reg, affected_config_check, wake_ack_reg, hung_reg;
  int fails, checked, cyc, n;
  ssm_row_t rows [9];
  ssm_supervisor uut (.clk, .reset_n, .low_ctl_in, .low_ctl_write, .high_ctl_in, .high_ctl_write, .power_mode,
    .wake_request, .soft_reset, .low_side_control_reg, .high_side_control_reg, .state_reg, .low_side_settle_flag,
    .high_side_settle_flag, .fast_wake_reg, .affected_config_check, .wake_ack_reg, .hung_reg);
  // ****************************************
  // Clock, timeout and helper tasks
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] lo, input logic [5:0] hi);
    low_ctl_in = lo;
    high_ctl_in = hi;
    low_ctl_write = 1'h1;
    high_ctl_write = 1'h1;
    @(negedge clk);
    low_ctl_write = 1'h0;
    high_ctl_write = 1'h0;
    // One idle edge between writes keeps the strobe from falling and rising in one step.
    @(negedge clk);
  endtask
  // Counts cycles until both settle flags are down; the limit keeps a stuck flag from hanging the run.
  task automatic settle();
    n = 0;
    while ((low_side_settle_flag | high_side_settle_flag) === 1'h1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wake();
    wake_request = 1'h1;
    @(negedge clk);
    wake_request = 1'h0;
    n = 1;
    while (wake_ack_reg !== 1'h1 && n < 3100) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reset_n, low_ctl_write, high_ctl_write, wake_request, soft_reset, low_ctl_in, high_ctl_in} = '0;
    power_mode = ssm_pkg::SSM_ACTIVE;
    {fails, checked, cyc} = '0;
    rows = '{'{6'h00, 6'h00, 2'h0, 8'h00, 8'h02}, '{6'h10, 6'h10, 2'h0, 8'h44, 8'h01}, '{6'h10, 6'h10, 2'h3, 8'h00, 8'h01},
      '{6'h3F, 6'h3A, 2'h3, 8'h50, 8'h03}, '{6'h3F, 6'h3A, 2'h1, 8'hF5, 8'h03}, '{6'h1F, 6'h1A, 2'h3, 8'hF5, 8'h02},
      '{6'h1F, 6'h22, 2'h3, 8'hF0, 8'h03}, '{6'h12, 6'h22, 2'h0, 8'h51, 8'h00}, '{6'h02, 6'h00, 2'h1, 8'h10, 8'h00}};
    repeat (2) @(negedge clk);
    check(8'(fast_wake_reg), 8'h01);
    reset_n = 1'h1;
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].lo, rows[i].hi);
      power_mode = ssm_pkg::ssm_power_t'(rows[i].pm);
      repeat (3) @(negedge clk);
      check(state_reg, rows[i].st);
      check({6'h00, fast_wake_reg, affected_config_check}, rows[i].fa);
      check({2'h0, high_side_control_reg}, {2'h0, rows[i].hi});
    end
    power_mode = ssm_pkg::SSM_ACTIVE;
    wr(6'h10, 6'h10);
    wr(6'h1F, 6'h1F);
    settle();
    check(8'(n inside {[38:42]}), 8'h01);
    wr(6'h10, 6'h1A);
    settle();
    check(8'(n inside {[2998:3002]}), 8'h01);
    power_mode = ssm_pkg::SSM_DEEP;
    repeat (25) @(negedge clk);
    wake();
    check(8'(n inside {[2995:3005]}), 8'h01);
    wr(6'h1F, 6'h1F);
    settle();
    wake();
    check(8'(n inside {[1:3]}), 8'h01);
    power_mode = ssm_pkg::SSM_ACTIVE;
    wr(6'h3F, 6'h3A);
    settle();
    power_mode = ssm_pkg::SSM_DEEP;
    @(negedge clk);
    wake();
    check({7'h00, hung_reg}, 8'h01);
    check(8'(n == 3100), 8'h01);
    soft_reset = 1'h1;
    @(negedge clk);
    soft_reset = 1'h0;
    @(negedge clk);
    check({1'h0, hung_reg, low_side_control_reg}, 8'h00);
    check({2'h0, high_side_control_reg}, 8'h00);
    // Affected setting again, but with a long pause in deep sleep before the interrupt.
    power_mode = ssm_pkg::SSM_ACTIVE;
    wr(6'h3F, 6'h3A);
    settle();
    power_mode = ssm_pkg::SSM_DEEP;
    repeat (3000) @(negedge clk);
    wake();
    check({7'h00, hung_reg}, 8'h00);
    check(8'(n inside {[1:3]}), 8'h01);
    close_out();
  end
endmodule
